// ### sbce_pkg.sv
/*
 * Shared constants and types for the nibble-serial LED-128 cipher engine:
 * serial strobe bit positions, APB register map, cipher tables, cycle counts.
 * Assumes a single 200 MHz clock domain; no other file is needed.
 */
package sbce_pkg;

    // control input bit positions
    localparam int CI_DATA  = 0;
    localparam int CI_KEY   = 1;
    localparam int CI_LDPT  = 2;
    localparam int CI_LDKEY = 3;
    localparam int CI_GETCT = 4;
    localparam int CI_START = 5;

    // result output bit positions
    localparam int RO_CT   = 0;
    localparam int RO_DONE = 1;

    // apb register byte offsets
    localparam logic [7:0] OFS_INT_STATUS = 8'h00;
    localparam logic [7:0] OFS_INT_MASK   = 8'h04;
    localparam logic [7:0] OFS_ENGINE     = 8'h08;

    // reset values and interrupt bit positions
    localparam logic [1:0] INT_STATUS_RST = 2'h0;
    localparam logic [1:0] INT_MASK_RST   = 2'h0;
    localparam int         EV_DONE        = 0;
    localparam int         EV_START       = 1;

    // cipher geometry and schedule
    localparam int         KEY_BITS  = 128;
    localparam int         BLK_BITS  = 64;
    localparam logic [3:0] LAST_NIB  = 4'hf;
    localparam logic [1:0] LAST_RND  = 2'h3;
    localparam logic [3:0] LAST_KEY  = 4'hc;
    localparam logic [5:0] RC_RST    = 6'h00;
    localparam int         ENC_CYCLES = 1744;

    // first-column constants for a 128-bit key, rows 0..3
    localparam logic [15:0] KS_COL0 = 16'h8923;

    // 4-bit sbox, entry 0 in the top nibble
    localparam logic [63:0] SBOX_TBL = 64'hc56b90ad3ef84712;

    // serial mixing matrix, row-major, entry (0,0) in the top nibble
    localparam logic [63:0] MIX_TBL = 64'h41228656bea922fb;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_KEY  = 2'b01,
        ST_SUB  = 2'b10,
        ST_MIX  = 2'b11
    } sbce_state_t;

endpackage : sbce_pkg

// ### sbce_top.sv
/*
 * Nibble-serial LED-128 encryption engine with bit-serial load and unload,
 * strobed from an 8-bit control port, plus an APB status/interrupt block.
 * Assumes the control port is asynchronous to pclk and that the controller
 * only loads while the done flag is high.
 */
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - The engine encrypts a 64-bit block under a 128-bit key with the LED cipher.
// - One nibble is worked per cycle through a single shared datapath.
// - Plaintext, key and ciphertext move one bit per cycle, most significant bit first.
// - A start strobe on control bit 5 launches encryption of the loaded plaintext.
// - Each idle cycle the ciphertext strobe on bit 4 is high, the next ciphertext bit appears.
// - Each idle cycle the key strobe on bit 3 is high, the key register shifts one bit; the key bit on bit 1 is ignored.
// - Each idle cycle the plaintext strobe on bit 2 is high and the ciphertext strobe on bit 4 is low, the data bit on bit 0 is taken.
// - A done flag is 1 when idle after encryption and the ciphertext bit has its own output.
// - Every key bit is stored as zero whatever the serial key input carries.
module sbce_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  control_input_port,
    output logic      [7:0]  result_output_port,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);

    // nibble idx of a 64-bit word, nibble 0 in the top bits
    function automatic logic [3:0] nib(input logic [63:0] v, input logic [3:0] i);
        nib = v[{~i, 2'b11} -: 4];
    endfunction : nib

    // multiply in gf(16) modulo x^4 + x + 1
    function automatic logic [3:0] gmul(input logic [3:0] a, input logic [3:0] b);
        logic [3:0] p;
        logic [3:0] x;
        p = 4'h0;
        x = a;
        for (int k = 0; k < 4; k++) begin
            if (b[k]) begin
                p = p ^ x;
            end
            x = {x[2:0], 1'b0} ^ (x[3] ? 4'h3 : 4'h0);
        end
        gmul = p;
    endfunction : gmul

    // one output nibble of shift-rows then mix-columns
    function automatic logic [3:0] mix_nib(input logic [63:0] s, input logic [3:0] i);
        logic [3:0] acc;
        logic [1:0] kk;
        acc = 4'h0;
        for (int k = 0; k < 4; k++) begin
            kk = 2'(k);
            acc = acc ^ gmul(nib(sbce_pkg::MIX_TBL, {i[3:2], kk}),
                             nib(s, {kk, 2'(i[1:0] + kk)}));
        end
        mix_nib = acc;
    endfunction : mix_nib

    // add-constant value for nibble i under round constant rc
    function automatic logic [3:0] rc_nib(input logic [3:0] i, input logic [5:0] rc);
        logic [15:0] k0;
        k0 = sbce_pkg::KS_COL0;
        case (i[1:0])
            2'h0:    rc_nib = k0[{~i[3:2], 2'b11} -: 4];
            2'h1:    rc_nib = i[2] ? {1'b0, rc[2:0]} : {1'b0, rc[5:3]};
            default: rc_nib = 4'h0;
        endcase
    endfunction : rc_nib

    // input synchroniser: three flops and a plain stage; no agree filter, since it would
    // swallow the one-cycle start pulse and garble a bit stream that changes every clock
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] sync3;
    logic [5:0] ctl;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
            sync3 <= 6'h00;
            ctl   <= 6'h00;
        end else begin
            sync1 <= control_input_port[5:0];   // bits 7..6 never sampled
            sync2 <= sync1;
            sync3 <= sync2;
            ctl   <= sync3;
        end
    end

    sbce_pkg::sbce_state_t state;
    sbce_pkg::sbce_state_t next_state;
    logic [63:0]  st;
    logic [63:0]  nb;
    logic [127:0] key;
    logic [3:0]   idx;
    logic [1:0]   rnd;
    logic [3:0]   kidx;
    logic [5:0]   rc;

    // strobe decode; loads and unloads only act while idle
    wire idle      = (state == sbce_pkg::ST_IDLE);
    wire go        = idle && ctl[sbce_pkg::CI_START];
    wire shift_ct  = idle && ctl[sbce_pkg::CI_GETCT];
    wire shift_pt  = idle && ctl[sbce_pkg::CI_LDPT] && !shift_ct;
    wire shift_key = idle && ctl[sbce_pkg::CI_LDKEY];
    wire last_nib  = (idx == sbce_pkg::LAST_NIB);
    wire [5:0] rc_step = {rc[4:0], ~(rc[5] ^ rc[4])};
    wire [63:0] khalf  = kidx[0] ? key[63:0] : key[127:64];

    // the one shared nibble datapath, indexed by idx
    wire [3:0] cur_nib = nib(st, idx);
    wire [3:0] sub_out = nib(sbce_pkg::SBOX_TBL, cur_nib ^ rc_nib(idx, rc));
    wire [3:0] key_out = cur_nib ^ nib(khalf, idx);
    wire [3:0] mix_out = mix_nib(st, idx);

    // sequencer: key add, then 4 rounds of sub and mix, 12 times, final key add
    always_comb begin
        next_state = state;
        case (state)
            sbce_pkg::ST_IDLE: if (go) next_state = sbce_pkg::ST_KEY;
            sbce_pkg::ST_KEY:  if (last_nib) begin
                next_state = (kidx == sbce_pkg::LAST_KEY) ? sbce_pkg::ST_IDLE : sbce_pkg::ST_SUB;
            end
            sbce_pkg::ST_SUB:  if (last_nib) next_state = sbce_pkg::ST_MIX;
            sbce_pkg::ST_MIX:  if (last_nib) begin
                next_state = (rnd == sbce_pkg::LAST_RND) ? sbce_pkg::ST_KEY : sbce_pkg::ST_SUB;
            end
            default:           next_state = sbce_pkg::ST_IDLE;
        endcase
    end

    // counters and round constant
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= sbce_pkg::ST_IDLE;
            idx   <= 4'h0;
            rnd   <= 2'h0;
            kidx  <= 4'h0;
            rc    <= sbce_pkg::RC_RST;
        end else begin
            state <= next_state;
            idx   <= idle ? 4'h0 : idx + 4'h1;
            if (go) begin
                kidx <= 4'h0;
                rnd  <= 2'h0;
                rc   <= sbce_pkg::RC_RST;
            end
            if (last_nib && state == sbce_pkg::ST_KEY) begin
                kidx <= kidx + 4'h1;
            end
            if (last_nib && state == sbce_pkg::ST_MIX) begin
                rnd <= rnd + 2'h1;
            end
            // constant steps once at the start of every round
            if (last_nib && next_state == sbce_pkg::ST_SUB) begin
                rc <= rc_step;
            end
        end
    end

    // state register: serial load/unload when idle, one nibble per cycle when busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= 64'h0;
            nb <= 64'h0;
        end else begin
            case (state)
                sbce_pkg::ST_KEY: st[{~idx, 2'b11} -: 4] <= key_out;
                sbce_pkg::ST_SUB: st[{~idx, 2'b11} -: 4] <= sub_out;
                sbce_pkg::ST_MIX: begin
                    // mix reads the whole old state, so results park in nb
                    nb[{~idx, 2'b11} -: 4] <= mix_out;
                    if (last_nib) st <= {nb[63:4], mix_out};
                end
                default: begin
                    if (shift_ct) st <= {st[62:0], 1'b0};
                    else if (shift_pt) st <= {st[62:0], ctl[sbce_pkg::CI_DATA]};
                end
            endcase
        end
    end

    // key register: shifts msb first but always stores zero bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key <= 128'h0;
        end else if (shift_key) begin
            key <= {key[126:0], 1'b0};
        end
    end

    // result port: ciphertext msb straight from the state flops
    assign result_output_port = {6'h00, idle, st[63]};

    // apb slave: always ready, read data captured in the setup cycle
    wire setup_ph  = psel && !penable;
    wire wr_acc    = psel && penable && pwrite;
    wire hit_stat  = (paddr == sbce_pkg::OFS_INT_STATUS);
    wire hit_mask  = (paddr == sbce_pkg::OFS_INT_MASK);
    wire hit_eng   = (paddr == sbce_pkg::OFS_ENGINE);
    wire mapped    = hit_stat || hit_mask || hit_eng;
    logic [1:0] int_status;
    logic [1:0] int_mask;
    wire [1:0] ev_set = {go, (state == sbce_pkg::ST_KEY) && (next_state == sbce_pkg::ST_IDLE)};
    wire [1:0] ev_clr = (wr_acc && hit_stat) ? pwdata[1:0] : 2'h0;
    wire [31:0] rd_mux = hit_stat ? {30'h0, int_status} :
                         hit_mask ? {30'h0, int_mask} :
                         hit_eng  ? {20'h0, kidx, rnd, state, 3'h0, idle} : 32'h0;

    assign pready = 1'b1;

    // sticky events: a set in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= sbce_pkg::INT_STATUS_RST;
            int_mask   <= sbce_pkg::INT_MASK_RST;
            prdata     <= 32'h0;
            pslverr    <= 1'b0;
            irq        <= 1'b0;
        end else begin
            int_status <= (int_status & ~ev_clr) | ev_set;
            if (wr_acc && hit_mask) int_mask <= pwdata[1:0];
            if (setup_ph) begin
                prdata  <= rd_mux;
                pslverr <= !mapped;
            end
            irq <= |(((int_status & ~ev_clr) | ev_set) & int_mask);
        end
    end

    // helper: busy cycle counter, read only by assertions
    logic [11:0] busy_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_cnt <= 12'h000;
        end else begin
            busy_cnt <= go ? 12'h000 : (idle ? busy_cnt : busy_cnt + 12'h001);
        end
    end

    // checks
    key_stays_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        key == 128'h0) else $error("key register holds a one bit");
    start_goes_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
        go |=> !result_output_port[sbce_pkg::RO_DONE] [*8]) else $error("start not accepted");
    enc_length_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(idle) |-> busy_cnt == 12'(sbce_pkg::ENC_CYCLES)) else $error("wrong encrypt length");
    ct_shift_a: assert property (@(posedge pclk) disable iff (!presetn)
        shift_ct |=> result_output_port[sbce_pkg::RO_CT] == $past(st[62])) else $error("ct bit stuck");
    pt_shift_a: assert property (@(posedge pclk) disable iff (!presetn)
        shift_pt |=> st[0] == $past(ctl[sbce_pkg::CI_DATA])) else $error("pt bit lost");
    upper_out_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        result_output_port[7:2] == 6'h00) else $error("upper outputs driven");
    done_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(result_output_port[sbce_pkg::RO_DONE]) |->
            $past(state == sbce_pkg::ST_KEY && kidx == sbce_pkg::LAST_KEY && last_nib))
        else $error("done raised before the last key add");
    one_nibble_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == sbce_pkg::ST_SUB) |=> ((st ^ $past(st)) & ~(64'hf << {~$past(idx), 2'b00})) == 64'h0)
        else $error("more than one nibble changed");
    irq_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 irq == |(int_status & $past(int_mask)))
        else $error("irq out of step");

    // sequencer checks: mix must not disturb the state it is still reading, kidx stays within LAST_KEY, start restarts the schedule
    mix_parks_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == sbce_pkg::ST_MIX && !last_nib) |=> $stable(st))
        else $error("state changed during mix");
    kidx_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
        !idle |-> kidx <= sbce_pkg::LAST_KEY)
        else $error("key add count overrun");
    start_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
        go |=> (kidx == 4'h0 && rnd == 2'h0 && rc == sbce_pkg::RC_RST && idx == 4'h0))
        else $error("schedule not restarted");

    // main scenarios reached
    start_seen_c:  cover property (@(posedge pclk) disable iff (!presetn) go);
    done_seen_c:   cover property (@(posedge pclk) disable iff (!presetn) $rose(idle));
    unload_seen_c: cover property (@(posedge pclk) disable iff (!presetn) shift_ct [*8]);
    irq_seen_c:    cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    refused_c:     cover property (@(posedge pclk) disable iff (!presetn) !idle && ctl[5]);

endmodule : sbce_top

`default_nettype wire

// ### sbce_ctl_model.sv
/*
 * Controller model for the cipher engine: drives the 8-bit control port.
 * Assumes the bench's pclk and the engine's result port; pins move on edges.
 */
`timescale 1ns/1ps
`default_nettype none
module sbce_ctl_model (
    input  wire logic       pclk,
    input  wire logic [7:0] result_output_port,
    output logic      [7:0] control_input_port
);
    logic [1:0] spare = 2'h0; // pins 7..6, which the engine must ignore

    initial control_input_port = 8'h00;

    // one pin word, changed just after an edge so the synchroniser sees it whole
    task automatic put(input logic [5:0] w);
        @(posedge pclk);
        control_input_port <= {spare, w};
    endtask : put

    // key then plaintext, msb first; idle gap flushes the pin pipeline
    task automatic load(input logic [127:0] key, input logic [63:0] pt, output logic ok);
        int n;
        n = 0;
        while (result_output_port[1] !== 1'b1 && n < 4000) begin
            @(posedge pclk);
            n++;
        end
        ok = (n < 4000);
        for (int i = 127; i >= 0; i--) put({4'h2, key[i], 1'b0});
        for (int i = 63; i >= 0; i--) put({4'h1, 1'b0, pt[i]});
        put(6'h00);
        repeat (6) @(posedge pclk);
    endtask : load

    // single-cycle launch
    task automatic start();
        put(6'h20);
        put(6'h00);
    endtask : start

    // all strobes high while busy; a real engine refuses every one
    task automatic poke();
        repeat (4) @(posedge pclk);
        repeat (20) put(6'h3f);
        put(6'h00);
    endtask : poke

    // getct held for 64 clocks; each bit read as it surfaces behind the pin pipeline
    task automatic unload(output logic [63:0] ct);
        ct[63] = result_output_port[0];
        for (int k = 0; k < 68; k++) begin
            put((k < 64) ? 6'h10 : 6'h00);
            #1 if (k >= 5) ct[67 - k] = result_output_port[0];
        end
    endtask : unload
endmodule : sbce_ctl_model
`default_nettype wire

// ### serial_block_cipher_engine_test.sv
/*
 * Bench for the cipher engine: controller model on the pins, apb master
 * for status, mask and engine registers. Assumes the engine rtl and package.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin \
    mismatches++; $display("Error at %0t: %s", $time, msg); end end
module serial_block_cipher_engine_test;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [7:0]  control_input_port;
    logic [7:0]  result_output_port;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    int          mismatches  = 0;
    int          comparisons = 0;

    always #2.5 pclk = ~pclk;

    sbce_top uut (.pclk(pclk), .presetn(presetn), .control_input_port(control_input_port),
        .result_output_port(result_output_port), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq));
    sbce_ctl_model ctl (.pclk(pclk), .result_output_port(result_output_port),
        .control_input_port(control_input_port));

    // setup, then access held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        `CHECK(n < 50, 1'b1, "bus hang")
    endtask : apb

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    task automatic test_reset();
        `CHECK(result_output_port, 8'h02, "reset outputs")
        `CHECK(irq, 1'b0, "reset irq")
        apb(1'b0, sbce_pkg::OFS_INT_STATUS, 32'h0);
        `CHECK(rd, 32'h0, "status reset")
        apb(1'b0, sbce_pkg::OFS_INT_MASK, 32'h0);
        `CHECK(rd, 32'h0, "mask reset")
        apb(1'b0, sbce_pkg::OFS_ENGINE, 32'h0);
        `CHECK(rd[0], 1'b1, "engine idle")
        $display("test_reset done");
    endtask : test_reset

    // load, launch, time the busy span, unload and compare
    task automatic run_vec(input logic [127:0] key, input logic [63:0] pt,
                           input logic [63:0] exp, input logic busy_poke, input string name);
        logic        ok;
        logic [63:0] ct;
        int          n;
        n = 0;
        ctl.load(key, pt, ok);
        `CHECK(ok, 1'b1, "idle wait")
        ctl.start();
        while (result_output_port[1] !== 1'b0 && n < 10) begin @(posedge pclk); #1; n++; end
        `CHECK(n < 10, 1'b1, "start not taken")
        n = 0;
        fork
            if (busy_poke) ctl.poke();
            while (result_output_port[1] === 1'b0 && n < 3000) begin
                n++;
                @(posedge pclk);
                #1;
            end
        join
        `CHECK(n, sbce_pkg::ENC_CYCLES, "busy length")
        `CHECK(result_output_port[7:2], 6'h00, "spare outputs")
        ctl.unload(ct);
        `CHECK(ct, exp, "ciphertext")
        $display("%s done", name);
    endtask : run_vec

    // events stick, mask gates irq, write one clears, read-only and unmapped places
    task automatic test_irq();
        apb(1'b0, sbce_pkg::OFS_INT_STATUS, 32'h0);
        `CHECK(rd, 32'h3, "both events")
        `CHECK(irq, 1'b0, "masked irq")
        apb(1'b1, sbce_pkg::OFS_INT_MASK, 32'h1);
        repeat (3) @(posedge pclk);
        `CHECK(irq, 1'b1, "irq raised")
        apb(1'b1, sbce_pkg::OFS_INT_STATUS, 32'h1);
        repeat (3) @(posedge pclk);
        `CHECK(irq, 1'b0, "irq cleared")
        apb(1'b0, sbce_pkg::OFS_INT_STATUS, 32'h0);
        `CHECK(rd, 32'h2, "one bit cleared")
        apb(1'b1, sbce_pkg::OFS_INT_STATUS, 32'h2);
        apb(1'b1, sbce_pkg::OFS_ENGINE, 32'h0);
        apb(1'b0, sbce_pkg::OFS_ENGINE, 32'h0);
        `CHECK(rd[0], 1'b1, "engine read only")
        apb(1'b0, 8'h0c, 32'h0);
        `CHECK({err, rd}, {1'b1, 32'h0}, "unmapped read")
        $display("test_irq done");
    endtask : test_irq

    // main sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        #1;
        test_reset();
        run_vec('0, 64'h0, 64'h3decb2a0850cdba1, 1'b0, "vec_zero");
        test_irq();
        ctl.spare = 2'h3;
        run_vec({128{1'b1}}, 64'h0123456789abcdef, 64'hda261393c73be9ce, 1'b0, "vec_ones");
        `CHECK(irq, 1'b1, "irq on done")
        ctl.spare = 2'h0;
        run_vec({2{64'h0123456789abcdef}}, 64'h12153524c0895e81, 64'h29db5fe262572f4e,
                1'b1, "vec_busy");
        give_verdict();
    end

    // hang guard, about six and a half times the expected run
    initial begin
        #200000;
        mismatches++;
        $display("Error at %0t: timeout", $time);
        give_verdict();
    end
endmodule : serial_block_cipher_engine_test
`default_nettype wire
